//--- verilog/tw_pkg.sv
// Shared constants and types for the two-wire slave transmitter
`default_nettype none
package tw_pkg;
   // Register byte offsets on the bus
   localparam logic [3:0] OWN_ADDR_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS   = 4'h4;
   localparam logic [3:0] DATA_OFS     = 4'h8;
   localparam logic [3:0] CONTROL_OFS  = 4'hc;
   // Status codes with prescaler bits masked
   localparam logic [7:0] CODE_OWN_READ  = 8'ha8;
   localparam logic [7:0] CODE_ARB_READ  = 8'hb0;
   localparam logic [7:0] CODE_DATA_ACK  = 8'hb8;
   localparam logic [7:0] CODE_DATA_NACK = 8'hc0;
   localparam logic [7:0] CODE_LAST_ACK  = 8'hc8;
   localparam logic [7:0] CODE_NO_INFO   = 8'hf8;
   localparam logic [7:0] CODE_BUS_ERROR = 8'h00;
   // Field positions in the status view
   localparam int unsigned CODE_MSB     = 7;
   localparam int unsigned CODE_LSB     = 3;
   localparam int unsigned PRESCALE_MSB = 1;
   // Reset values and fixed patterns
   localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET     = 8'h00;
   localparam logic [7:0] IDLE_BYTE      = 8'hff;
   localparam logic [1:0] PRESCALE_RESET = 2'h0;
   localparam logic [6:0] GEN_CALL_ADDR  = 7'h00;
   localparam logic [3:0] BYTE_BITS      = 4'h8;
   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic job_done_flag;
      logic ack_enable;
      logic start_request;
      logic stop_request;
      logic write_collision;
      logic enable;
      logic spare_hi;
      logic spare_lo;
   } ctrl_t;
   localparam ctrl_t CONTROL_RESET = 8'h00;
   // Filtered bus line levels
   typedef struct packed {
      logic scl;
      logic sda;
   } link_t;
   localparam link_t LINK_IDLE = 2'h3;
   // Slave transmitter sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WAIT, ST_TX, ST_TX_ACK, ST_BUSERR
   } state_t;
endpackage : tw_pkg
`default_nettype wire

//--- verilog/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int unsigned WIDTH = 2,
   parameter logic [1:0]  RESET_VALUE = 2'h3
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);
   generate
      if (WIDTH != 2) begin : g_bad
         $error("pin_sync serves two lines only");
      end
   endgenerate
   // One chain per line, level moves once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic level_reg;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1_reg    <= RESET_VALUE[i];
               s2_reg    <= RESET_VALUE[i];
               s3_reg    <= RESET_VALUE[i];
               level_reg <= RESET_VALUE[i];
            end else begin
               s1_reg <= pin_i[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) level_reg <= s3_reg;
            end
         end
         assign level_o[i] = level_reg;
      end
   endgenerate
endmodule : pin_sync
`default_nettype wire

//--- verilog/pair_buffer.sv
// Small circular buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
         $error("pair_buffer depth must be a power of two, at least 2");
      end
   endgenerate
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0]   count_reg;
   wire              push = in_valid_i & in_ready_o;
   wire              pop  = out_valid_o & out_ready_i;
   // Honest full and empty from the occupancy count
   assign in_ready_o  = count_reg != FULL_COUNT;
   assign out_valid_o = count_reg != '0;
   assign out_data_o  = mem_reg[rd_ptr_reg];
   // Pointers wrap naturally for power-of-two depth
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end
   // Storage needs no reset
   always_ff @(posedge clk_i) begin
      if (push) mem_reg[wr_ptr_reg] <= in_data_i;
   end
endmodule : pair_buffer
`default_nettype wire

//--- verilog/tw_slave_tx.sv
// Two-wire slave transmitter with status codes and Wishbone registers
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Own read address acked: flag, status a8
// - Lost arbitration then read: status b0
// - Data acked: status b8, await next byte
// - Data not acked: status c0, unaddressed
// - Last byte acked anyway: status c8
// - Unaddressed: recognise addresses only if ack enabled
// - Start request on c0/c8 issues start later
// - Flag clear reads status f8
// - Start or stop mid frame: status 00
// - Recovery: unaddressed, clear stop, release lines
// - Repeated start begins a new address phase
// - Status in bits 7:3, prescaler 1:0
// - Flag set in wait state holds clock line low
// - After last byte, ignore further clocking
// - General call only when address bit 0 set
module tw_slave_tx #(
   parameter int unsigned BUF_DEPTH = 2
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        arb_lost_i,
   output logic             start_issue_o
);
   generate
      if (BUF_DEPTH < 2) begin : g_bad
         $error("tw_slave_tx needs a buffer of at least two bytes");
      end
   endgenerate

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   tw_pkg::state_t state_reg;
   tw_pkg::state_t state_next;
   tw_pkg::ctrl_t  ctrl_reg;
   tw_pkg::link_t  lk;
   tw_pkg::link_t  lk_prev_reg;
   logic [3:0]     cnt_reg;
   logic [3:0]     cnt_next;
   logic [7:0]     shift_reg;
   logic [7:0]     shift_next;
   logic [7:0]     code_reg;
   logic [7:0]     code_next;
   logic [7:0]     own_addr_reg;
   logic [7:0]     data_hold_reg;
   logic [1:0]     prescale_reg;
   logic           last_reg;
   logic           last_next;
   logic           got_ack_reg;
   logic           got_ack_next;
   logic           is_read_reg;
   logic           is_read_next;
   logic           sda_oe_reg;
   logic           sda_oe_next;
   logic           start_pend_reg;
   logic           busy_reg;
   logic           ack_reg;
   logic [31:0]    dat_reg;
   logic           flag_set;
   logic           pop;
   logic           release_idle;
   logic           buf_in_ready;
   logic           buf_out_valid;
   logic [7:0]     buf_out_data;

   // ----------------------------------------
   // Line sampling and bus conditions
   // ----------------------------------------
   pin_sync #(
      .WIDTH       (2),
      .RESET_VALUE (tw_pkg::LINK_IDLE)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   ({scl_i, sda_i}),
      .level_o (lk)
   );

   // Edges and frame conditions from filtered levels
   wire scl_rise   = lk.scl & ~lk_prev_reg.scl;
   wire scl_fall   = ~lk.scl & lk_prev_reg.scl;
   wire both_high  = lk.scl & lk_prev_reg.scl;
   wire start_cond = both_high & lk_prev_reg.sda & ~lk.sda;
   wire stop_cond  = both_high & ~lk_prev_reg.sda & lk.sda;

   // ----------------------------------------
   // Bus slave decode
   // ----------------------------------------
   tw_pkg::ctrl_t wd;
   assign wd = tw_pkg::ctrl_t'(wb_dat_i[7:0]);
   wire job_flag   = ctrl_reg.job_done_flag;
   wire req        = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire hit_own    = wb_adr_i == tw_pkg::OWN_ADDR_OFS;
   wire hit_status = wb_adr_i == tw_pkg::STATUS_OFS;
   wire hit_data   = wb_adr_i == tw_pkg::DATA_OFS;
   wire hit_ctrl   = wb_adr_i == tw_pkg::CONTROL_OFS;
   wire lane0      = wb_sel_i[0];
   wire data_push  = hit_data & wb_we_i & lane0 & job_flag;
   wire acc        = req & ~(data_push & ~buf_in_ready);
   wire wr         = acc & wb_we_i & lane0;
   wire wr_own     = wr & hit_own;
   wire wr_status  = wr & hit_status;
   wire wr_data    = wr & hit_data;
   wire wr_ctrl    = wr & hit_ctrl;
   wire flag_clear = wr_ctrl & wd.job_done_flag;
   wire recover    = flag_clear & wd.stop_request;

   // Status view: masked code, zero bit, prescaler
   wire [7:0] code_view = job_flag ? code_reg : tw_pkg::CODE_NO_INFO;
   wire [7:0] status_view = {code_view[tw_pkg::CODE_MSB:tw_pkg::CODE_LSB], 1'b0,
                             prescale_reg[tw_pkg::PRESCALE_MSB:0]};
   wire [7:0] rd_byte = hit_own    ? own_addr_reg  :
                        hit_status ? status_view   :
                        hit_data   ? data_hold_reg :
                        hit_ctrl   ? ctrl_reg      : 8'h00;

   // ----------------------------------------
   // Outgoing byte buffer
   // ----------------------------------------
   pair_buffer #(
      .WIDTH (8),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (wr_data & job_flag),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (wb_dat_i[7:0]),
      .out_valid_o (buf_out_valid),
      .out_ready_i (pop),
      .out_data_o  (buf_out_data)
   );

   // Empty buffer sends released line, all ones
   wire [7:0] byte_in = buf_out_valid ? buf_out_data : tw_pkg::IDLE_BYTE;

   // ----------------------------------------
   // Address match and frame position
   // ----------------------------------------
   wire own_read_hit = ctrl_reg.ack_enable & shift_reg[0] &
                       (shift_reg[7:1] == own_addr_reg[7:1]);
   wire gc_hit       = ctrl_reg.ack_enable & own_addr_reg[0] & ~shift_reg[0] &
                       (shift_reg[7:1] == tw_pkg::GEN_CALL_ADDR);
   wire in_frame     = (state_reg == tw_pkg::ST_ADDR && cnt_reg != 4'h0) ||
                       state_reg == tw_pkg::ST_ADDR_ACK ||
                       state_reg == tw_pkg::ST_TX ||
                       state_reg == tw_pkg::ST_TX_ACK;
   wire bus_err      = in_frame & (start_cond | stop_cond);
   wire fsm_free     = ctrl_reg.enable & ~recover & ~bus_err;
   wire addr_end     = state_reg == tw_pkg::ST_ADDR && scl_fall && cnt_reg == tw_pkg::BYTE_BITS;
   wire addr_ack_end = state_reg == tw_pkg::ST_ADDR_ACK && scl_fall;
   wire tx_ack_end   = state_reg == tw_pkg::ST_TX_ACK && scl_fall;
   wire need_byte    = code_reg == tw_pkg::CODE_OWN_READ ||
                       code_reg == tw_pkg::CODE_ARB_READ ||
                       code_reg == tw_pkg::CODE_DATA_ACK;

   // ----------------------------------------
   // Transmit sequencer
   // ----------------------------------------
   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      shift_next   = shift_reg;
      code_next    = code_reg;
      last_next    = last_reg;
      got_ack_next = got_ack_reg;
      is_read_next = is_read_reg;
      sda_oe_next  = sda_oe_reg;
      flag_set     = 1'b0;
      pop          = 1'b0;
      release_idle = 1'b0;
      case (state_reg)
         tw_pkg::ST_IDLE: begin
            if (start_cond) begin
               state_next = tw_pkg::ST_ADDR;
               cnt_next   = 4'h0;
            end
         end
         tw_pkg::ST_ADDR: begin
            if (start_cond) begin
               cnt_next = 4'h0;
            end else if (stop_cond) begin
               state_next = tw_pkg::ST_IDLE;
            end else if (scl_rise && cnt_reg != tw_pkg::BYTE_BITS) begin
               shift_next = {shift_reg[6:0], lk.sda};
               cnt_next   = cnt_reg + 4'h1;
            end else if (addr_end) begin
               if (own_read_hit || gc_hit) begin
                  is_read_next = own_read_hit;
                  sda_oe_next  = 1'b1;
                  state_next   = tw_pkg::ST_ADDR_ACK;
               end else begin
                  state_next = tw_pkg::ST_IDLE;
               end
            end
         end
         tw_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
               sda_oe_next = 1'b0;
               if (is_read_reg) begin
                  flag_set   = 1'b1;
                  code_next  = arb_lost_i ? tw_pkg::CODE_ARB_READ
                                          : tw_pkg::CODE_OWN_READ;
                  state_next = tw_pkg::ST_WAIT;
               end else begin
                  state_next = tw_pkg::ST_IDLE;
               end
            end
         end
         tw_pkg::ST_WAIT: begin
            if (flag_clear && need_byte) begin
               pop         = buf_out_valid;
               shift_next  = byte_in;
               last_next   = ~wd.ack_enable;
               sda_oe_next = ~byte_in[7];
               cnt_next    = 4'h1;
               state_next  = tw_pkg::ST_TX;
            end else if (flag_clear) begin
               release_idle = 1'b1;
               state_next   = tw_pkg::ST_IDLE;
            end
         end
         tw_pkg::ST_TX: begin
            if (scl_fall && cnt_reg == tw_pkg::BYTE_BITS) begin
               sda_oe_next = 1'b0;
               state_next  = tw_pkg::ST_TX_ACK;
            end else if (scl_fall) begin
               sda_oe_next = ~shift_reg[6];
               shift_next  = {shift_reg[6:0], 1'b1};
               cnt_next    = cnt_reg + 4'h1;
            end
         end
         tw_pkg::ST_TX_ACK: begin
            if (scl_rise) begin
               got_ack_next = ~lk.sda;
            end else if (scl_fall) begin
               flag_set   = 1'b1;
               state_next = tw_pkg::ST_WAIT;
               if (!got_ack_reg) code_next = tw_pkg::CODE_DATA_NACK;
               else if (last_reg) code_next = tw_pkg::CODE_LAST_ACK;
               else code_next = tw_pkg::CODE_DATA_ACK;
            end
         end
         tw_pkg::ST_BUSERR: begin
            state_next = tw_pkg::ST_BUSERR;
         end
         default: begin
            state_next = tw_pkg::ST_IDLE;
         end
      endcase
      // Disable and recovery drop to unaddressed with lines released
      if (!ctrl_reg.enable || recover) begin
         state_next   = tw_pkg::ST_IDLE;
         sda_oe_next  = 1'b0;
         pop          = 1'b0;
         release_idle = 1'b0;
      end
      if (bus_err) begin
         state_next  = tw_pkg::ST_BUSERR;
         code_next   = tw_pkg::CODE_BUS_ERROR;
         flag_set    = 1'b1;
         sda_oe_next = 1'b0;
      end
   end

   // Sequencer state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg   <= tw_pkg::ST_IDLE;
         cnt_reg     <= 4'h0;
         shift_reg   <= tw_pkg::IDLE_BYTE;
         code_reg    <= tw_pkg::CODE_NO_INFO;
         last_reg    <= 1'b0;
         got_ack_reg <= 1'b0;
         is_read_reg <= 1'b0;
         sda_oe_reg  <= 1'b0;
         lk_prev_reg <= tw_pkg::LINK_IDLE;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         shift_reg   <= shift_next;
         code_reg    <= code_next;
         last_reg    <= last_next;
         got_ack_reg <= got_ack_next;
         is_read_reg <= is_read_next;
         sda_oe_reg  <= sda_oe_next;
         lk_prev_reg <= lk;
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg      <= tw_pkg::CONTROL_RESET;
         own_addr_reg  <= tw_pkg::OWN_ADDR_RESET;
         data_hold_reg <= tw_pkg::DATA_RESET;
         prescale_reg  <= tw_pkg::PRESCALE_RESET;
      end else begin
         if (flag_set) ctrl_reg.job_done_flag <= 1'b1;
         else if (flag_clear) ctrl_reg.job_done_flag <= 1'b0;
         if (wr_ctrl) begin
            ctrl_reg.ack_enable    <= wd.ack_enable;
            ctrl_reg.start_request <= wd.start_request;
            ctrl_reg.enable        <= wd.enable;
            ctrl_reg.stop_request  <= wd.stop_request & ~wd.job_done_flag;
         end
         if (wr_data) ctrl_reg.write_collision <= ~job_flag;
         if (wr_data && job_flag) data_hold_reg <= wb_dat_i[7:0];
         if (wr_own) own_addr_reg <= wb_dat_i[7:0];
         if (wr_status) prescale_reg <= wb_dat_i[1:0];
      end
   end

   // Bus answer, start request and bus occupancy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg        <= 1'b0;
         dat_reg        <= 32'h0000_0000;
         start_pend_reg <= 1'b0;
         busy_reg       <= 1'b0;
      end else begin
         ack_reg <= acc;
         if (acc) dat_reg <= {24'h00_0000, rd_byte};
         if (release_idle && wd.start_request) start_pend_reg <= 1'b1;
         else if (start_issue_o || !ctrl_reg.enable) start_pend_reg <= 1'b0;
         if (start_cond) busy_reg <= 1'b1;
         else if (stop_cond) busy_reg <= 1'b0;
      end
   end

   // Outputs; clock held low only while waiting on software
   assign wb_ack_o      = ack_reg;
   assign wb_dat_o      = dat_reg;
   assign scl_o         = 1'b0;
   assign scl_oe_o      = state_reg == tw_pkg::ST_WAIT;
   assign sda_o         = 1'b0;
   assign sda_oe_o      = sda_oe_reg;
   assign start_issue_o = start_pend_reg & ~busy_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_own_read_code: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_ack_end && is_read_reg && !arb_lost_i && fsm_free
      |=> job_flag && code_reg == tw_pkg::CODE_OWN_READ && scl_oe_o)
      else $error("own read address not reported");
   chk_arb_read_code: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_ack_end && is_read_reg && arb_lost_i && fsm_free
      |=> job_flag && code_reg == tw_pkg::CODE_ARB_READ)
      else $error("read after lost arbitration not reported");
   chk_data_ack_code: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_ack_end && got_ack_reg && !last_reg && fsm_free
      |=> code_reg == tw_pkg::CODE_DATA_ACK ##0 state_reg == tw_pkg::ST_WAIT)
      else $error("acked byte not reported");
   chk_nack_release: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_ack_end && !got_ack_reg && fsm_free
      |=> code_reg == tw_pkg::CODE_DATA_NACK ##1 !sda_oe_o)
      else $error("nacked byte not reported");
   chk_last_ack_code: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_ack_end && got_ack_reg && last_reg && fsm_free
      |=> code_reg == tw_pkg::CODE_LAST_ACK)
      else $error("acked last byte not reported");
   chk_addr_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
      addr_end && !ctrl_reg.ack_enable && fsm_free |=> state_reg == tw_pkg::ST_IDLE)
      else $error("address taken while ack disabled");
   chk_start_issue: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_clear && !need_byte && wd.start_request && state_reg == tw_pkg::ST_WAIT
      && ctrl_reg.enable && !recover |=> start_pend_reg)
      else $error("start request lost");
   chk_no_info_read: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && hit_status && !job_flag
      |=> wb_ack_o && wb_dat_o[7:3] == tw_pkg::CODE_NO_INFO[7:3])
      else $error("status not f8 while flag clear");
   chk_bus_error: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_err |=> job_flag && code_reg == tw_pkg::CODE_BUS_ERROR && !sda_oe_o)
      else $error("bus error not reported");
   chk_recover_release: assert property (@(posedge clk_i) disable iff (rst_i)
      recover && !bus_err |=> !ctrl_reg.stop_request && !scl_oe_o && !sda_oe_o)
      else $error("recovery did not release bus");
   chk_status_layout: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && hit_status |=> wb_dat_o[2:0] == {1'b0, $past(prescale_reg)})
      else $error("status layout wrong");
   chk_stretch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(job_flag) && state_reg == tw_pkg::ST_WAIT && !flag_clear |=> scl_oe_o)
      else $error("clock not stretched while flag set");
endmodule : tw_slave_tx
`default_nettype wire

//--- sim/i2c_master_model.sv
// Behavioural two-wire bus master that reads from the device
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
   parameter int unsigned HALF = 12
) (
   input  wire logic clk_i,
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   input  wire logic dev_scl_i,
   input  wire logic dev_sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Low phase is split in two quarters around the data change
   localparam int unsigned QUARTER = HALF / 2;
   // ----------------------------------------
   // Wired-AND lines with pull-ups
   // ----------------------------------------
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;
   assign scl_o = scl_m & (~scl_oe_i | dev_scl_i);
   assign sda_o = sda_m & (~sda_oe_i | dev_sda_i);
   task automatic hp;
      repeat (HALF) @(posedge clk_i);
   endtask : hp
   task automatic qp;
      repeat (QUARTER) @(posedge clk_i);
   endtask : qp
   // Start, also repeated start at a byte boundary
   task automatic start;
      sda_m <= 1'b1; hp; scl_m <= 1'b1; hp; sda_m <= 1'b0; hp; scl_m <= 1'b0; hp;
   endtask : start
   task automatic stop;
      sda_m <= 1'b0; hp; scl_m <= 1'b1; hp; sda_m <= 1'b1; hp;
   endtask : stop
   // One bit of 25 cycles, waits out clock stretching
   task automatic bit_x(input logic b, output logic r);
      sda_m <= b; qp; scl_m <= 1'b1; @(posedge clk_i);
      while (scl_o !== 1'b1) @(posedge clk_i);
      hp; r = sda_o; scl_m <= 1'b0; qp;
   endtask : bit_x
   // Nine bits MSB first, last one is the acknowledge slot
   task automatic xfer(input logic [8:0] t, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) bit_x(t[i], r[i]);
   endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

//--- sim/test_tw_slave_tx.sv
// Self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
`default_nettype none
module test_tw_slave_tx;
   // ----------------------------------------
   // Signals, counters, design and partner
   // ----------------------------------------
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        arb = 1'b0, ack, scl, sda, scl_oe, sda_oe, issue, dscl, dsda;
   logic [3:0]  adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, q, rdat;
   logic [8:0]  rx;
   int          fails = 0, tests_run = 0, cycles = 0, issues = 0;
   initial forever #2.5 clk_i = ~clk_i;
   tw_slave_tx DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .scl_i(scl), .sda_i(sda), .scl_o(dscl), .scl_oe_o(scl_oe), .sda_o(dsda), .sda_oe_o(sda_oe),
      .arb_lost_i(arb), .start_issue_o(issue));
   i2c_master_model m (.clk_i(clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .dev_scl_i(dscl),
      .dev_sda_i(dsda), .scl_o(scl), .sda_o(sda));
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // Hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin fails++; end_of_test(); end
   end
   // Start requests are one-cycle pulses, so count them
   always @(posedge clk_i) if (issue === 1'b1) issues <= issues + 1;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
   endtask : chk
   // Classic Wishbone single cycle
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; dat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat; cyc <= 1'b0; stb <= 1'b0; @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [3:0] a, input logic [7:0] d); wb(1'b1, a, d); endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e); wb(1'b0, a, 8'h0); chk(q, e);
   endtask : rd
   function automatic logic [31:0] st(input logic [7:0] c); return {24'h0, c | 8'h03};
   endfunction : st
   task automatic t_reset;
      rd(tw_pkg::STATUS_OFS, 32'hf8);
      rd(tw_pkg::CONTROL_OFS, 32'h0);
      wr(tw_pkg::OWN_ADDR_OFS, 8'ha4); wr(tw_pkg::STATUS_OFS, 8'h03); wr(tw_pkg::CONTROL_OFS, 8'h44);
      rd(tw_pkg::STATUS_OFS, st(tw_pkg::CODE_NO_INFO));
   endtask : t_reset
   task automatic t_read_three;
      m.start(); m.xfer(9'h14b, rx); chk(32'(rx[0]), 32'h0);
      rd(tw_pkg::STATUS_OFS, st(tw_pkg::CODE_OWN_READ));
      chk(32'(scl_oe), 32'h1);
      wr(tw_pkg::DATA_OFS, 8'h5a); wr(tw_pkg::CONTROL_OFS, 8'hc4);
      m.xfer(9'h1fe, rx); chk(32'(rx[8:1]), 32'h5a);
      rd(tw_pkg::STATUS_OFS, st(tw_pkg::CODE_DATA_ACK));
      wr(tw_pkg::DATA_OFS, 8'ha5); wr(tw_pkg::CONTROL_OFS, 8'h84);
      m.xfer(9'h1fe, rx); chk(32'(rx[8:1]), 32'ha5);
      rd(tw_pkg::STATUS_OFS, st(tw_pkg::CODE_LAST_ACK));
      wr(tw_pkg::CONTROL_OFS, 8'he4); m.xfer(9'h1ff, rx); chk(32'(rx[8:1]), 32'hff);
      chk(32'(issues), 32'h0);
      m.stop(); repeat (10) @(posedge clk_i); chk(32'(issues), 32'h1);
      m.start(); m.xfer(9'h1ff, rx); m.stop(); chk(32'(issues), 32'h1);
   endtask : t_read_three
   task automatic t_nack;
      arb <= 1'b1; m.start(); m.xfer(9'h14b, rx); arb <= 1'b0;
      rd(tw_pkg::STATUS_OFS, st(tw_pkg::CODE_ARB_READ));
      wr(tw_pkg::DATA_OFS, 8'h3c); wr(tw_pkg::CONTROL_OFS, 8'hc4);
      m.xfer(9'h1ff, rx); chk(32'(rx[8:1]), 32'h3c);
      rd(tw_pkg::STATUS_OFS, st(tw_pkg::CODE_DATA_NACK));
      wr(tw_pkg::CONTROL_OFS, 8'h84); m.stop(); m.start(); m.xfer(9'h14b, rx);
      chk(32'(rx[0]), 32'h1);
      m.stop(); wr(tw_pkg::CONTROL_OFS, 8'h44); m.start(); m.xfer(9'h001, rx);
      chk(32'(rx[0]), 32'h1);
      m.stop(); wr(tw_pkg::OWN_ADDR_OFS, 8'ha5); m.start(); m.xfer(9'h001, rx);
      chk(32'(rx[0]), 32'h0);
      m.stop();
   endtask : t_nack
   task automatic t_bus_error;
      m.start(); repeat (3) m.bit_x(1'b1, rx[0]); m.start(); repeat (8) @(posedge clk_i);
      rd(tw_pkg::STATUS_OFS, st(tw_pkg::CODE_BUS_ERROR));
      wr(tw_pkg::CONTROL_OFS, 8'hd4); rd(tw_pkg::CONTROL_OFS, 32'h44);
      chk(32'(scl_oe | sda_oe), 32'h0);
      m.stop();
   endtask : t_bus_error
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset(); t_read_three(); t_nack(); t_bus_error();
      end_of_test();
   end
endmodule : test_tw_slave_tx
`default_nettype wire
